// file: mua_defs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 25 MHz APB clock; included by mua_frame and mua_top.
// Behaviour
// - Mask-clear write of one disables channel interrupt
// - Start bit one schedules one later access
// - Start accepted only while engine enabled
// - Start bit self-clears after access completes
// - Writes to busy channel register discarded
// - Direction bit one writes, zero reads
// - Acknowledge bit set when PHY acknowledged read
// - Five-bit field gives PHY register number
// - Five-bit field gives target PHY address
// - Data field written out or loaded on read
// - Link source select resets zero, engine-derived
// - Link interrupt enable gates link-change interrupts
// - Five-bit field names monitored PHY address
// - Bus clock is pclk over divider plus one; even dividers give plus two, zero stops it
// - Raw done flag set on finish, write-one clears
// - Mask-set write of one enables channel interrupt
// - Raw link-change flag set on link change
`ifndef MUA_DEFS_SVH
`define MUA_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define MUA_OFS_CONTROL      12'h004
`define MUA_OFS_LINK         12'h00c
`define MUA_OFS_LINK_RAW     12'h010
`define MUA_OFS_LINK_MASKED  12'h014
`define MUA_OFS_DONE_RAW     12'h020
`define MUA_OFS_DONE_MASKED  12'h024
`define MUA_OFS_MASK_SET     12'h028
`define MUA_OFS_MASK_CLEAR   12'h02c
`define MUA_OFS_ACCESS0      12'h080
`define MUA_OFS_SELECT0      12'h084
`define MUA_OFS_ACCESS1      12'h088
`define MUA_OFS_SELECT1      12'h08c

// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define MUA_CTL_ENABLE_BIT   30
`define MUA_ACC_START_BIT    31
`define MUA_ACC_WRITE_BIT    30
`define MUA_ACC_ACK_BIT      29
`define MUA_ACC_REG_LSB      21
`define MUA_ACC_PHY_LSB      16
`define MUA_SEL_SRC_BIT      7
`define MUA_SEL_IRQEN_BIT    6
`define MUA_DIV_RESET        16'h00ff
`define MUA_SEL_RESET        8'h00

// ---------------------------------------------------------------
// Frame and timing
// ---------------------------------------------------------------
`define MUA_FRAME_BITS       64
`define MUA_PHY_STATUS_REG   5'h01
`define MUA_LINK_UP_BIT      2
`define MUA_POLL_GAP_US      100
`define MUA_CLK_MHZ          25
`define MUA_POLL_GAP_CYC     (`MUA_POLL_GAP_US * `MUA_CLK_MHZ)

`endif

// file: mua_pkg.sv
// Types shared by the access engine and its frame shifter.
// Assumes mua_defs.svh is on the include path.
package mua_pkg;
   typedef enum logic [1:0] {MUA_SRC_CH0, MUA_SRC_CH1, MUA_SRC_POLL} mua_src_t;
   typedef enum logic [1:0] {MUA_IDLE, MUA_RUN, MUA_FINISH} mua_state_t;
endpackage

// file: mua_frame_if.sv
// Request/answer bundle between the engine and the frame shifter.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface mua_frame_if;
   logic        start;
   logic        write;
   logic [4:0]  phy;
   logic [4:0]  regnum;
   logic [15:0] wdata;
   logic        done;
   logic        ack;
   logic [15:0] rdata;
   modport engine  (output start, write, phy, regnum, wdata, input done, ack, rdata);
   modport shifter (input start, write, phy, regnum, wdata, output done, ack, rdata);
endinterface

// file: mua_frame.sv
// Clause 22 frame shifter: runs one frame per start pulse.
// Assumes tick is a one-cycle pulse at twice the bus clock rate.
`timescale 1ns/1ps
module mua_frame
   import mua_pkg::*;
(
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   tick,
   input  wire logic   mdio_in_sync,
   output logic        mdc,
   output logic        mdio_out,
   output logic        mdio_oe,
   mua_frame_if.shifter f
);
`include "mua_defs.svh"

   logic [63:0] shreg;
   logic [6:0]  bitnum;
   logic        busy;
   logic        rd;
   logic [15:0] rx;
   logic        ack_seen;

   // ---------------------------------------------------------------
   // Shift out on falling, sample on rising edge of mdc
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shreg    <= '0;
         bitnum   <= '0;
         busy     <= 1'b0;
         rd       <= 1'b0;
         rx       <= '0;
         ack_seen <= 1'b0;
         mdc      <= 1'b0;
         mdio_out <= 1'b1;
         mdio_oe  <= 1'b0;
         f.done   <= 1'b0;
         f.ack    <= 1'b0;
         f.rdata  <= '0;
      end
      else
      begin
         f.done <= 1'b0;
         if (!busy && f.start)
         begin
            // Preamble, start, opcode, addresses, turnaround, data
            shreg  <= {32'hffffffff, 2'b01, f.write ? 2'b01 : 2'b10, f.phy, f.regnum,
                       2'b10, f.wdata};
            rd     <= !f.write;
            bitnum <= '0;
            busy   <= 1'b1;
            ack_seen <= 1'b0;
         end
         else if (busy && tick)
         begin
            mdc <= !mdc;
            if (mdc && bitnum == 7'(`MUA_FRAME_BITS + 1))
            begin
               // End on a falling edge so every frame starts with the clock low
               busy    <= 1'b0;
               mdio_oe <= 1'b0;
               f.done  <= 1'b1;
               f.ack   <= ack_seen;
               f.rdata <= rx;
            end
            else if (mdc)
            begin
               // Falling edge: bit n-1 goes out; reads release from turnaround
               mdio_out <= shreg[63];
               mdio_oe  <= !(rd && bitnum >= 7'd47);
               shreg    <= {shreg[62:0], 1'b1};
            end
            else
            begin
               // Second turnaround bit low means the PHY answered
               if (rd && bitnum == 7'd48)
                  ack_seen <= !mdio_in_sync;
               if (rd && bitnum >= 7'd49)
                  rx <= {rx[14:0], mdio_in_sync};
               bitnum <= bitnum + 7'd1;
            end
         end
      end
   end
endmodule

// file: mua_top.sv
// User access engine: APB registers, channel scheduler, link poller.
// Assumes an APB master on pclk and a PHY on the mgmt pins.
`timescale 1ns/1ps
module mua_top
   import mua_pkg::*;
#(
   parameter int POLL_GAP_CYC = `MUA_POLL_GAP_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             mgmt_bus_clock,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic        mdio_in,
   output logic             cmd_done_irq,
   output logic             link_change_irq
);
`include "mua_defs.svh"

   mua_frame_if fr ();

   logic [15:0] mgmt_clock_divider;
   logic        engine_en;
   logic [31:0] user_access [2];
   logic [7:0]  phy_monitor_select [2];
   logic [1:0]  cmd_done_flag_raw;
   logic [1:0]  cmd_done_mask_set;
   logic [1:0]  link_change_flag_raw;
   logic [31:0] link_state;
   logic [15:0] div_cnt;
   logic        tick;
   logic        mdio_s1;
   logic        mdio_s2;
   logic        mdc_int;
   logic        mdo_int;
   logic        mdoe_int;
   mua_state_t  state;
   mua_src_t    src;
   logic        poll_idx;
   logic [31:0] gap_cnt;
   logic [1:0]  done_pulse;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] next_prdata;

   function automatic logic decode(input logic [11:0] a, input logic [11:0] ofs);
      decode = (a == ofs);
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // ---------------------------------------------------------------
   // Management clock divider and input synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end
      else if (mgmt_clock_divider == 16'h0000)
      begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end
      else
      begin
         // Toggle every (div+1)/2 cycles; odd ratios round the half period
         tick    <= (div_cnt == 16'h0000);
         div_cnt <= (div_cnt >= (mgmt_clock_divider >> 1)) ? 16'h0000 : div_cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end
      else
      begin
         mdio_s1 <= mdio_in;
         mdio_s2 <= mdio_s1;
      end
   end

   mua_frame u_frame (
      .pclk         (pclk),
      .presetn      (presetn),
      .tick         (tick),
      .mdio_in_sync (mdio_s2),
      .mdc          (mdc_int),
      .mdio_out     (mdo_int),
      .mdio_oe      (mdoe_int),
      .f            (fr.shifter)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mgmt_bus_clock <= 1'b0;
         mdio_out       <= 1'b1;
         mdio_oe        <= 1'b0;
      end
      else
      begin
         mgmt_bus_clock <= mdc_int;
         mdio_out       <= mdo_int;
         mdio_oe        <= mdoe_int;
      end
   end

   // ---------------------------------------------------------------
   // Scheduler: channel 0 first, then 1, polling in the gaps
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state      <= MUA_IDLE;
         src        <= MUA_SRC_POLL;
         poll_idx   <= 1'b0;
         gap_cnt    <= '0;
         fr.start   <= 1'b0;
         fr.write   <= 1'b0;
         fr.phy     <= '0;
         fr.regnum  <= '0;
         fr.wdata   <= '0;
         done_pulse <= '0;
      end
      else
      begin
         fr.start   <= 1'b0;
         done_pulse <= '0;
         case (state)
            MUA_IDLE:
            begin
               if (gap_cnt != 32'h0)
                  gap_cnt <= gap_cnt - 32'h1;
               if (engine_en && user_access[0][`MUA_ACC_START_BIT])
               begin
                  src       <= MUA_SRC_CH0;
                  fr.start  <= 1'b1;
                  fr.write  <= user_access[0][`MUA_ACC_WRITE_BIT];
                  fr.phy    <= user_access[0][`MUA_ACC_PHY_LSB +: 5];
                  fr.regnum <= user_access[0][`MUA_ACC_REG_LSB +: 5];
                  fr.wdata  <= user_access[0][15:0];
                  state     <= MUA_RUN;
               end
               else if (engine_en && user_access[1][`MUA_ACC_START_BIT])
               begin
                  src       <= MUA_SRC_CH1;
                  fr.start  <= 1'b1;
                  fr.write  <= user_access[1][`MUA_ACC_WRITE_BIT];
                  fr.phy    <= user_access[1][`MUA_ACC_PHY_LSB +: 5];
                  fr.regnum <= user_access[1][`MUA_ACC_REG_LSB +: 5];
                  fr.wdata  <= user_access[1][15:0];
                  state     <= MUA_RUN;
               end
               else if (engine_en && gap_cnt == 32'h0)
               begin
                  src       <= MUA_SRC_POLL;
                  fr.start  <= 1'b1;
                  fr.write  <= 1'b0;
                  fr.phy    <= phy_monitor_select[poll_idx][4:0];
                  fr.regnum <= `MUA_PHY_STATUS_REG;
                  fr.wdata  <= '0;
                  state     <= MUA_RUN;
               end
            end
            MUA_RUN:
               if (fr.done)
               begin
                  // Start bit must be clear before IDLE looks again, or it reruns
                  done_pulse[0] <= (src == MUA_SRC_CH0);
                  done_pulse[1] <= (src == MUA_SRC_CH1);
                  state         <= MUA_FINISH;
               end
            MUA_FINISH:
            begin
               if (src == MUA_SRC_POLL)
               begin
                  poll_idx <= !poll_idx;
                  gap_cnt  <= 32'(POLL_GAP_CYC);
               end
               state <= MUA_IDLE;
            end
            default:
               state <= MUA_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Link state table and link-change flags
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link_state           <= '0;
         link_change_flag_raw <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
            if (wr_en && decode(paddr, `MUA_OFS_LINK_RAW) && pwdata[i])
               link_change_flag_raw[i] <= 1'b0;
         if (state == MUA_FINISH && src == MUA_SRC_POLL)
         begin
            // Link state always comes from polling; no pin source exists
            link_state[fr.phy] <= fr.ack && fr.rdata[`MUA_LINK_UP_BIT];
            for (int i = 0; i < 2; i++)
               if (phy_monitor_select[i][4:0] == fr.phy &&
                   link_state[fr.phy] != (fr.ack && fr.rdata[`MUA_LINK_UP_BIT]))
                  link_change_flag_raw[i] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mgmt_clock_divider <= `MUA_DIV_RESET;
         engine_en          <= 1'b0;
         phy_monitor_select[0] <= `MUA_SEL_RESET;
         phy_monitor_select[1] <= `MUA_SEL_RESET;
         cmd_done_mask_set  <= '0;
      end
      else if (wr_en)
      begin
         if (decode(paddr, `MUA_OFS_CONTROL))
         begin
            engine_en          <= pwdata[`MUA_CTL_ENABLE_BIT];
            mgmt_clock_divider <= pwdata[15:0];
         end
         if (decode(paddr, `MUA_OFS_SELECT0))
            phy_monitor_select[0] <= {1'b0, pwdata[6], 1'b0, pwdata[4:0]};
         if (decode(paddr, `MUA_OFS_SELECT1))
            phy_monitor_select[1] <= {1'b0, pwdata[6], 1'b0, pwdata[4:0]};
         if (decode(paddr, `MUA_OFS_MASK_SET))
            cmd_done_mask_set <= cmd_done_mask_set | pwdata[1:0];
         if (decode(paddr, `MUA_OFS_MASK_CLEAR))
            cmd_done_mask_set <= cmd_done_mask_set & ~pwdata[1:0];
      end
   end

   // Channel registers and done flags; hardware completion beats software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         user_access[0]    <= '0;
         user_access[1]    <= '0;
         cmd_done_flag_raw <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (wr_en && decode(paddr, `MUA_OFS_DONE_RAW) && pwdata[i])
               cmd_done_flag_raw[i] <= 1'b0;
            if (wr_en && !user_access[i][`MUA_ACC_START_BIT] &&
                decode(paddr, i == 0 ? `MUA_OFS_ACCESS0 : `MUA_OFS_ACCESS1))
               user_access[i] <= {pwdata[31] && engine_en, pwdata[30],
                                  user_access[i][29], 3'b000, pwdata[25:0]};
            if (done_pulse[i])
            begin
               user_access[i][`MUA_ACC_START_BIT] <= 1'b0;
               cmd_done_flag_raw[i] <= 1'b1;
               if (!user_access[i][`MUA_ACC_WRITE_BIT])
               begin
                  user_access[i][`MUA_ACC_ACK_BIT] <= fr.ack;
                  user_access[i][15:0]             <= fr.rdata;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // APB read path and interrupt outputs
   // ---------------------------------------------------------------
   always_comb
   begin
      next_prdata = 32'h0;
      case (paddr)
         `MUA_OFS_CONTROL:     next_prdata = {1'b0, engine_en, 14'h0, mgmt_clock_divider};
         `MUA_OFS_LINK:        next_prdata = link_state;
         `MUA_OFS_LINK_RAW:    next_prdata = {30'h0, link_change_flag_raw};
         `MUA_OFS_LINK_MASKED: next_prdata = {30'h0, link_change_flag_raw &
                                   {phy_monitor_select[1][6], phy_monitor_select[0][6]}};
         `MUA_OFS_DONE_RAW:    next_prdata = {30'h0, cmd_done_flag_raw};
         `MUA_OFS_DONE_MASKED: next_prdata = {30'h0, cmd_done_flag_raw & cmd_done_mask_set};
         `MUA_OFS_MASK_SET,
         `MUA_OFS_MASK_CLEAR:  next_prdata = {30'h0, cmd_done_mask_set};
         `MUA_OFS_ACCESS0:     next_prdata = user_access[0];
         `MUA_OFS_SELECT0:     next_prdata = {24'h0, phy_monitor_select[0]};
         `MUA_OFS_ACCESS1:     next_prdata = user_access[1];
         `MUA_OFS_SELECT1:     next_prdata = {24'h0, phy_monitor_select[1]};
         default:              next_prdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata          <= '0;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         cmd_done_irq    <= 1'b0;
         link_change_irq <= 1'b0;
      end
      else
      begin
         // No wait states: ready rises in the first access cycle
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (rd_en)
            prdata <= next_prdata;
         cmd_done_irq    <= |(cmd_done_flag_raw & cmd_done_mask_set);
         link_change_irq <= |(link_change_flag_raw &
                              {phy_monitor_select[1][6], phy_monitor_select[0][6]});
      end
   end
endmodule

// file: mua_monitor.sv
// Port checker for mua_top: APB timing, interrupt gating, stopped clock.
// Assumes it is bound to mua_top and sees only that module's ports.
`timescale 1ns/1ps
module mua_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mgmt_bus_clock,
   input wire logic        cmd_done_irq,
   input wire logic        link_change_irq
);
   // ---
   // Shadow of the mask, enables and divider
   // ---
   logic       wr;
   logic [1:0] mask;
   logic [1:0] lien;
   logic       div0;
   assign wr = psel && penable && pwrite && pready;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         mask <= 2'h0;
      else if (wr && paddr == 12'h028)
         mask <= mask | pwdata[1:0];
      else if (wr && paddr == 12'h02c)
         mask <= mask & ~pwdata[1:0];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         lien <= 2'h0;
      else if (wr && paddr == 12'h084)
         lien[0] <= pwdata[6];
      else if (wr && paddr == 12'h08c)
         lien[1] <= pwdata[6];
   // Reset divider is nonzero, so the clock may run at first
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         div0 <= 1'b0;
      else if (wr && paddr == 12'h004)
         div0 <= pwdata[15:0] == 16'h0000;
   // ---
   // Properties
   // ---
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_clear_all;
      wr && paddr == 12'h02c && pwdata[1:0] == 2'h3;
   endsequence
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
      else $error("pready is not one access-cycle pulse");
   a_ready_cause: assert property (pready |-> penable && $past(psel && !penable))
      else $error("pready without a preceding setup");
   a_no_error: assert property (!pslverr)
      else $error("pslverr raised");
   a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
      else $error("prdata moved outside a read setup");
   a_mask_clear_quiet: assert property (s_clear_all |-> ##2 !cmd_done_irq)
      else $error("done irq after clearing both masks");
   a_mask_zero_quiet: assert property (mask == 2'h0 && $past(mask) == 2'h0 |-> !cmd_done_irq)
      else $error("done irq with no mask set");
   a_link_irq_gated: assert property (lien == 2'h0 && $past(lien) == 2'h0 |-> !link_change_irq)
      else $error("link irq with enables off");
   a_mdc_stopped: assert property (div0 && $past(div0, 3) |-> $stable(mgmt_bus_clock))
      else $error("bus clock moved with divider zero");
endmodule
bind mua_top mua_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .mgmt_bus_clock, .cmd_done_irq, .link_change_irq);

// file: mua_phy_model.sv
// Behavioural PHY answering one address on the management link.
// Assumes the line has a pull-up, so a released line reads one.
`timescale 1ns/1ps
module mua_phy_model #(
   parameter logic [4:0] PHY_ADDR = 5'h03
) (
   input  wire logic mdc,
   input  wire logic mdio_line,
   input  wire logic link_up,
   output logic      phy_oe,
   output logic      phy_out
);
   logic [15:0] mem [32];
   logic [12:0] hdr;
   logic [15:0] wd;
   logic [15:0] rd;
   int          ones = 0;
   int          n = 0;
   initial
   begin
      for (int i = 0; i < 32; i++)
         mem[i] = 16'ha500 + 16'(i);
      phy_oe = 1'b0;
      phy_out = 1'b1;
   end
   // Bits sampled on the rising edge, own data changed just after it
   always @(posedge mdc)
   begin
      if (n == 0)
      begin
         if (ones >= 32 && !mdio_line)
            n = 1;
         ones = mdio_line ? ones + 1 : 0;
      end
      else
      begin
         n = n + 1;
         if (n <= 14)
            hdr = {hdr[11:0], mdio_line};
         if (n > 16)
            wd = {wd[14:0], mdio_line};
         if (n == 15 && hdr[11:10] == 2'b10 && hdr[9:5] == PHY_ADDR)
         begin
            rd = hdr[4:0] == 5'h01 ? {mem[1][15:3], link_up, mem[1][1:0]} : mem[hdr[4:0]];
            phy_oe <= 1'b1;
            phy_out <= 1'b0;
         end
         else if (n >= 16 && n <= 31 && phy_oe)
            phy_out <= rd[31 - n];
         if (n == 32)
         begin
            if (hdr[11:10] == 2'b01 && hdr[9:5] == PHY_ADDR)
               mem[hdr[4:0]] = wd;
            phy_oe <= 1'b0;
            n = 0;
         end
      end
   end
endmodule

// file: tb.sv
// Register-level bench for mua_top with a PHY model at address 3.
// Assumes the port checker binds itself; divider 7 keeps frames short.
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        link_up = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready, pslverr, mdc, mo, moe, phy_oe, phy_out, c_irq, l_irq;
   wire         line = moe ? mo : (phy_oe ? phy_out : 1'b1);
   int          miscompares = 0;
   int          comparisons = 0;
   int          cycles = 0;
   mua_top #(.POLL_GAP_CYC(20)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mgmt_bus_clock(mdc), .mdio_out(mo),
      .mdio_oe(moe), .mdio_in(line), .cmd_done_irq(c_irq), .link_change_irq(l_irq));
   mua_phy_model #(.PHY_ADDR(5'h03)) phy (.mdc, .mdio_line(line), .link_up, .phy_oe,
      .phy_out);
   // ---
   // Bus and compare tasks
   // ---
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd(input logic [11:0] a, input string name, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, exp, r);
   endtask
   // Polls a register until the chosen bit equals the wanted level
   task automatic wait_bit(input logic [11:0] a, input int b, input logic v);
      do
         apb(1'b0, a, 32'h0);
      while (r[b] !== v);
   endtask
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
      forever #20 pclk = ~pclk;
   // Whole run needs roughly 6k cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         miscompares++;
         summarize();
      end
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, "control", 32'h0000_00ff);
      rd(12'h084, "select0", 32'h0);
      rd(12'h08c, "select1", 32'h0);
      apb(1'b1, 12'h3fc, 32'hffff_ffff);
      rd(12'h3fc, "unmapped", 32'h0);
      apb(1'b1, 12'h080, 32'h80a3_0000);
      rd(12'h080, "start while off", 32'h00a3_0000);
      $display("reset test done");
      apb(1'b1, 12'h004, 32'h4000_0007);
      apb(1'b1, 12'h028, 32'h3);
      rd(12'h028, "mask", 32'h3);
      apb(1'b1, 12'h080, 32'hc0a3_1234);
      apb(1'b1, 12'h080, 32'h4000_5555);
      rd(12'h080, "busy access0", 32'hc0a3_1234);
      wait_bit(12'h080, 31, 1'b0);
      check("write done", 32'h40a3_1234, r);
      check("phy reg5", 32'h1234, {16'h0, phy.mem[5]});
      rd(12'h020, "done raw", 32'h1);
      check("done irq", 32'h1, {31'h0, c_irq});
      apb(1'b1, 12'h020, 32'h1);
      rd(12'h020, "done cleared", 32'h0);
      apb(1'b1, 12'h088, 32'h80a3_0000);
      wait_bit(12'h088, 31, 1'b0);
      check("read ch1", 32'h20a3_1234, r);
      apb(1'b1, 12'h088, 32'h80a4_0000);
      wait_bit(12'h088, 31, 1'b0);
      check("no ack", 32'h0, {31'h0, r[29]});
      $display("single access test done");
      apb(1'b1, 12'h020, 32'h3);
      apb(1'b1, 12'h080, 32'hc063_beef);
      apb(1'b1, 12'h088, 32'h8063_0000);
      wait_bit(12'h088, 31, 1'b0);
      check("ordered read", 32'h2063_beef, r);
      rd(12'h020, "both done", 32'h3);
      apb(1'b1, 12'h02c, 32'h0);
      check("clear zero", 32'h1, {31'h0, c_irq});
      apb(1'b1, 12'h02c, 32'h1);
      rd(12'h028, "mask half", 32'h2);
      apb(1'b1, 12'h02c, 32'h3);
      rd(12'h024, "masked", 32'h0);
      check("irq off", 32'h0, {31'h0, c_irq});
      apb(1'b1, 12'h080, 32'h0063_0011);
      rd(12'h080, "no start", 32'h0063_0011);
      $display("ordering and mask test done");
      apb(1'b1, 12'h084, 32'h43);
      apb(1'b1, 12'h08c, 32'h03);
      rd(12'h084, "select0 set", 32'h43);
      link_up <= 1'b1;
      wait_bit(12'h010, 0, 1'b1);
      rd(12'h00c, "link", 32'h8);
      check("link irq", 32'h1, {31'h0, l_irq});
      apb(1'b1, 12'h010, 32'h1);
      rd(12'h010, "link raw", 32'h2);
      check("link irq off", 32'h0, {31'h0, l_irq});
      apb(1'b1, 12'h084, 32'h03);
      check("link irq gated", 32'h0, {31'h0, l_irq});
      $display("link test done");
      apb(1'b1, 12'h004, 32'h4000_0000);
      repeat (4) @(posedge pclk);
      r[0] = mdc;
      repeat (40) @(posedge pclk);
      check("clock still", {31'h0, r[0]}, {31'h0, mdc});
      $display("divider test done");
      summarize();
   end
endmodule
